// File: bench/rosm_relay_model.sv
`timescale 1ns/1ns
`default_nettype none

module rosm_relay_model (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // transfer link
   input wire logic xfer_strobe,
   input wire logic ack_en,
   output logic xfer_ack
);
   // ack one cycle after each strobe; a dead module just stays silent
   always_ff @(posedge clk) begin
      xfer_ack <= !rst && xfer_strobe && ack_en;
   end
endmodule : rosm_relay_model

`default_nettype wire

// File: bench/tb.sv
`timescale 1ns/1ns
`default_nettype none

module tb;
   import rosm_pkg::*;
   localparam int XC = 20;
   localparam int WC = 50;
   localparam logic [15:0] TW = 16'h5C3E; // arbitrary type word
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic oba = 1'b0;
   logic ack_en = 1'b1;
   logic [7:0] slot = 8'h00;
   logic [15:0] status_word = 16'h0000;
   rosm_req_t req = '0;
   rosm_rsp_t rsp;
   logic xfer_strobe, xfer_ack, wd_trip;
   logic [7:0] xfer_byte;
   logic [1:0] relay_out;
   logic [7:0] ob = 8'h00;
   logic [16:0] rd;
   logic [15:0] a, w;
   logic [31:0] seed = 32'h99CEA1E2;
   int n_errors = 0;
   int tests_run = 0;
   int cyc = 0;
   int n;

   rosm_slot_map #(.XFER_CYC(XC), .WD_CYC(WC), .TYPE_WORD(TW)) rosm_slot_map_i (.clk(clk), .rst(rst),
      .one_based_convention_addressing(oba), .slot(slot), .status_word(status_word), .req(req), .rsp(rsp),
      .xfer_strobe(xfer_strobe), .xfer_byte(xfer_byte), .xfer_ack(xfer_ack), .relay_out(relay_out),
      .wd_trip(wd_trip));
   rosm_relay_model rosm_relay_model_i (.clk(clk), .rst(rst), .xfer_strobe(xfer_strobe), .ack_en(ack_en),
      .xfer_ack(xfer_ack));

   always #10 clk = ~clk;

   // hang guard, far above the few hundred cycles the run needs
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         n_errors++;
         end_of_test();
      end
   end

   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction : xs

   // base of an area in the convention now selected
   function automatic logic [15:0] bs(input logic [15:0] zb, input logic [15:0] ob1);
      return oba ? ob1 : zb;
   endfunction : bs

   task automatic chk(input string nm, input logic [16:0] e, input logic [16:0] g);
      tests_run++;
      if (g !== e) begin
         n_errors++;
         $display("[ERR] %s exp %h got %h", nm, e, g);
      end
   endtask : chk

   // one request; the answer stands only in the cycle after the take edge
   task automatic xact(input logic [7:0] f, input logic [15:0] ad, input logic [15:0] wd);
      @(posedge clk);
      #1 req = {1'b1, f, ad, wd};
      @(posedge clk);
      #1 req.valid = 1'b0;
      rd = {rsp.err, rsp.data};
      chk("rsp_valid", 17'h1, {16'h0, rsp.valid});
   endtask : xact

   task automatic wstb(output int k);
      k = 0;
      do begin
         @(posedge clk);
         #1 k++;
      end while (xfer_strobe !== 1'b1 && k < 200);
   endtask : wstb

   task automatic end_of_test();
      $display("checks %0d errors %0d", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : end_of_test

   initial begin
      repeat (2) @(posedge clk);
      #1 rst = 1'b0;
      // same map walked in both address conventions
      for (int m = 0; m < 2; m++) begin
         seed = xs(seed);
         oba = m[0];
         slot = {4'h0, seed[11:8]};
         status_word = seed[31:16];
         for (int b = 0; b < 8; b++) begin
            seed = xs(seed);
            a = bs(SLOT_COIL_BASE_ZB, SLOT_COIL_BASE_OB) + 16'(8 * slot) + 16'(b);
            w = seed[0] ? 16'hFF00 : 16'h0000;
            xact(b[0] ? FC_WRITE_COILS : FC_WRITE_COIL, a, w);
            chk("coil_wr", {1'b0, w}, rd);
            if (b < 2) ob[b] = (w != 16'h0000);
            xact(FC_READ_COILS, a, 16'h0000);
            chk("coil_rd", {16'h0, (b < 2) ? ob[b] : 1'b0}, rd);
         end
         // bit 0 must survive the writes to the unused bits
         xact(FC_READ_COILS, bs(SLOT_COIL_BASE_ZB, SLOT_COIL_BASE_OB) + 16'(8 * slot), 16'h0000);
         chk("coil_keep", {16'h0, ob[0]}, rd);
         for (int b = 1; b < 9; b++) begin
            xact(FC_READ_INPUTS, bs(STAT_BIT_BASE_ZB, STAT_BIT_BASE_OB) + 16'(8 * slot) + 16'(b - 1), 16'h0);
            chk("stat_bit", {16'h0, status_word[7 + b]}, rd);
         end
         xact(FC_READ_INREG, bs(STAT_WORD_BASE_ZB, STAT_WORD_BASE_OB) + 16'(slot), 16'h0000);
         chk("stat_word", {1'b0, status_word}, rd);
         xact(FC_READ_INREG, bs(TYPE_WORD_BASE_ZB, TYPE_WORD_BASE_OB) + 16'(slot), 16'h0000);
         chk("type_word", {1'b0, TW}, rd);
         // allocated coils, one per used output bit
         for (int b = 0; b < 2; b++) begin
            w = {seed[b + 4], 15'h0000};
            xact(FC_WRITE_COIL, bs(ALLOC_COIL_BASE_ZB, ALLOC_COIL_BASE_OB) + 16'(b), w);
            chk("acoil_wr", {1'b0, w}, rd);
            ob[b] = seed[b + 4];
            xact(FC_READ_COILS, bs(ALLOC_COIL_BASE_ZB, ALLOC_COIL_BASE_OB) + 16'(b), 16'h0000);
            chk("acoil_rd", {16'h0, ob[b]}, rd);
         end
         xact(m[0] ? FC_WRITE_REGS : FC_WRITE_REG, bs(HOLD_REG_BASE_ZB, HOLD_REG_BASE_OB), seed[31:16]);
         chk("hold_wr", {1'b0, seed[31:16]}, rd);
         ob[1:0] = seed[17:16];
         xact(FC_READ_HOLD, bs(HOLD_REG_BASE_ZB, HOLD_REG_BASE_OB), 16'h0000);
         chk("hold_rd", {9'h000, ob}, rd);
         xact(8'h07, 16'h0000, 16'h0000);
         chk("bad_func", {1'b1, EXC_ILL_FUNC}, rd);
         xact(FC_READ_INREG, bs(STAT_WORD_BASE_ZB, STAT_WORD_BASE_OB) + 16'(slot) + 16'h0001, 16'h0000);
         chk("other_slot", {1'b1, EXC_ILL_ADDR}, rd);
         xact(FC_READ_INREG, bs(STAT_WORD_BASE_OB, STAT_WORD_BASE_ZB) + 16'(slot), 16'h0000);
         chk("wrong_conv", {1'b1, EXC_ILL_ADDR}, rd);
         $display("mode %0d done", m);
      end
      // relay 1 on, so the watchdog has something to switch off
      xact(FC_WRITE_COIL, bs(SLOT_COIL_BASE_ZB, SLOT_COIL_BASE_OB) + 16'(8 * slot), 16'hFF00);
      ob[0] = 1'b1;
      wstb(n);
      wstb(n);
      chk("period", 17'(XC), 17'(n));
      chk("xfer_byte", {9'h000, ob}, {9'h000, xfer_byte});
      repeat (3) @(posedge clk);
      #1 chk("relay", {15'h0, ob[1:0]}, {15'h0, relay_out});
      $display("link done");
      ack_en = 1'b0;
      n = 0;
      while (wd_trip !== 1'b1 && n < 400) begin
         @(posedge clk);
         #1 n++;
      end
      chk("wd_time", 17'h1, {16'h0, n > 2 * XC + WC && n <= 4 * XC + WC});
      chk("wd_off", 17'h0, {15'h0, relay_out});
      ack_en = 1'b1;
      wstb(n);
      repeat (3) @(posedge clk);
      #1 chk("wd_clear", 17'h0, {16'h0, wd_trip});
      chk("wd_relay", {15'h0, ob[1:0]}, {15'h0, relay_out});
      $display("watchdog done");
      end_of_test();
   end
endmodule : tb

`default_nettype wire

// File: core/rosm_pkg.sv
package rosm_pkg;

   // clock and timing, figures in their own units
   localparam int CLK_PERIOD_NS = 20;
   localparam int XFER_PERIOD_US = 6500;
   localparam int RESP_TIME_MS = 20;
   localparam int WD_TIME_MS = 500;
   // fixed transfer period, exact in whole cycles
   localparam int XFER_CYCLES = (XFER_PERIOD_US * 1000) / CLK_PERIOD_NS;
   // longest response time rounds down
   localparam int RESP_CYCLES = (RESP_TIME_MS * 1000000) / CLK_PERIOD_NS;
   // least watchdog time rounds up
   localparam int WD_CYCLES = (WD_TIME_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [1:0] WD_FAIL_LIMIT = 2'h3;

   // zero-based and one-based bases of each area
   localparam logic [15:0] STAT_BIT_BASE_ZB = 16'h0800;   // 2048
   localparam logic [15:0] STAT_BIT_BASE_OB = 16'h36B1;   // 14001
   localparam logic [15:0] STAT_WORD_BASE_ZB = 16'h0300;  // 768
   localparam logic [15:0] STAT_WORD_BASE_OB = 16'h8980;  // 35200
   localparam logic [15:0] TYPE_WORD_BASE_ZB = 16'h0400;  // 1024
   localparam logic [15:0] TYPE_WORD_BASE_OB = 16'h89E4;  // 35300
   localparam logic [15:0] SLOT_COIL_BASE_ZB = 16'h0400;  // 1024
   localparam logic [15:0] SLOT_COIL_BASE_OB = 16'h0BB9;  // 3001
   localparam logic [15:0] ALLOC_COIL_BASE_ZB = 16'h0000; // 0
   localparam logic [15:0] ALLOC_COIL_BASE_OB = 16'h0001; // 1
   localparam logic [15:0] HOLD_REG_BASE_ZB = 16'h0500;   // 1280
   localparam logic [15:0] HOLD_REG_BASE_OB = 16'hB415;   // 46101

   // function codes
   localparam logic [7:0] FC_READ_COILS = 8'h01;
   localparam logic [7:0] FC_READ_INPUTS = 8'h02;
   localparam logic [7:0] FC_READ_HOLD = 8'h03;
   localparam logic [7:0] FC_READ_INREG = 8'h04;
   localparam logic [7:0] FC_WRITE_COIL = 8'h05;
   localparam logic [7:0] FC_WRITE_REG = 8'h06;
   localparam logic [7:0] FC_WRITE_COILS = 8'h0F;
   localparam logic [7:0] FC_WRITE_REGS = 8'h10;

   // exception codes
   localparam logic [15:0] EXC_ILL_FUNC = 16'h0001;
   localparam logic [15:0] EXC_ILL_ADDR = 16'h0002;

   // output process byte
   localparam logic [7:0] OUT_RESET = 8'h00;
   localparam logic [7:0] OUT_USED_MASK = 8'h03;
   localparam logic [3:0] BIT_NONE = 4'h8;

   typedef struct packed {
      logic valid;
      logic [7:0] func;
      logic [15:0] addr;
      logic [15:0] wdata;
   } rosm_req_t;

   typedef struct packed {
      logic valid;
      logic err;
      logic [15:0] data;
   } rosm_rsp_t;

endpackage : rosm_pkg

// File: core/rosm_slot_map.sv
// Function
// R01 - output byte: bit0 relay1, bit1 relay2
// R02 - push outputs to module every 6.5 ms
// R03 - relay follows command within 20 ms
// R04 - master reaches values by modbus requests
// R05 - status bits by fc2 at bit formula
// R06 - status and type words by fc4
// R07 - slot coils written 5/15, read 1
// R08 - allocated coil area from address 0/1
// R09 - allocated holding area from 1280/46101
// R10 - zero-based or one-based addressing selectable
// R11 - three failed transfers then off after 500ms
// R12 - unused bits ignore writes, read zero
`timescale 1ns/1ns
`default_nettype none

module rosm_slot_map
   import rosm_pkg::*;
#(
   parameter int XFER_CYC = XFER_CYCLES,
   parameter int WD_CYC = WD_CYCLES,
   parameter logic [15:0] ALLOC_COIL = 16'h0000,
   parameter logic [15:0] ALLOC_REG = 16'h0000,
   parameter logic [3:0] ALLOC_BIT = 4'h0,
   parameter logic [15:0] TYPE_WORD = 16'h00A5 // arbitrary value
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // configuration
   input wire logic one_based_convention_addressing,
   input wire logic [7:0] slot,
   input wire logic [15:0] status_word,
   // modbus request and answer
   input wire rosm_req_t req,
   output var rosm_rsp_t rsp,
   // transfer to the relay module
   output logic xfer_strobe,
   output logic [7:0] xfer_byte,
   input wire logic xfer_ack,
   // relay drive
   output logic [1:0] relay_out,
   output logic wd_trip
);

   // bit offset inside an 8-bit slot area, BIT_NONE when outside
   function automatic logic [3:0] bit_sel(input logic [15:0] a, input logic [15:0] base,
                                          input logic [7:0] s);
      logic [15:0] rel;
      rel = a - base - {5'h00, s, 3'h0};
      bit_sel = (rel < 16'h0008) ? rel[3:0] : BIT_NONE;
   endfunction : bit_sel

   logic [7:0] out_byte;
   logic [7:0] applied;
   logic [31:0] xfer_cnt;
   logic [31:0] wd_cnt;
   logic [1:0] fail_cnt;
   logic ack_seen;
   logic xfer_tick;

   // base selection by addressing convention [R10]
   wire logic ob = one_based_convention_addressing;
   wire logic [15:0] b_sbit = ob ? STAT_BIT_BASE_OB : STAT_BIT_BASE_ZB;
   wire logic [15:0] b_sword = ob ? STAT_WORD_BASE_OB : STAT_WORD_BASE_ZB;
   wire logic [15:0] b_tword = ob ? TYPE_WORD_BASE_OB : TYPE_WORD_BASE_ZB;
   wire logic [15:0] b_scoil = ob ? SLOT_COIL_BASE_OB : SLOT_COIL_BASE_ZB;
   wire logic [15:0] b_acoil = ob ? ALLOC_COIL_BASE_OB : ALLOC_COIL_BASE_ZB;
   wire logic [15:0] b_hreg = ob ? HOLD_REG_BASE_OB : HOLD_REG_BASE_ZB;

   // function code classes; multi-item writes arrive one item per request [R04]
   wire logic fc_sbit = req.func == FC_READ_INPUTS;
   wire logic fc_inreg = req.func == FC_READ_INREG;
   wire logic fc_crd = req.func == FC_READ_COILS;
   wire logic fc_cwr = (req.func == FC_WRITE_COIL) || (req.func == FC_WRITE_COILS);
   wire logic fc_hrd = req.func == FC_READ_HOLD;
   wire logic fc_hwr = (req.func == FC_WRITE_REG) || (req.func == FC_WRITE_REGS);
   wire logic fc_ok = fc_sbit | fc_inreg | fc_crd | fc_cwr | fc_hrd | fc_hwr;

   // address decode of every area
   wire logic [3:0] st_bit = bit_sel(req.addr, b_sbit, slot);             // [R05]
   wire logic sw_hit = req.addr == (b_sword + {8'h00, slot});             // [R06]
   wire logic tw_hit = req.addr == (b_tword + {8'h00, slot});             // [R06]
   wire logic [3:0] sc_bit = bit_sel(req.addr, b_scoil, slot);            // [R07]
   wire logic [15:0] ac_rel = req.addr - b_acoil - ALLOC_COIL;            // [R08]
   wire logic [3:0] ac_bit = (ac_rel < 16'h0002) ? ac_rel[3:0] : BIT_NONE;
   wire logic hr_hit = req.addr == (b_hreg + ALLOC_REG);                  // [R09]
   wire logic [3:0] coil_idx = (sc_bit != BIT_NONE) ? sc_bit : ac_bit;
   wire logic coil_hit = coil_idx != BIT_NONE;

   wire logic addr_ok = (fc_sbit & (st_bit != BIT_NONE)) | (fc_inreg & (sw_hit | tw_hit)) |
                        ((fc_crd | fc_cwr) & coil_hit) | ((fc_hrd | fc_hwr) & hr_hit);

   // read data; only bits 0 and 1 of the output byte can hold a one [R12]
   wire logic [15:0] hr_word = {8'h00, out_byte} << ALLOC_BIT;           // [R09]
   wire logic [15:0] rd_data =
      fc_sbit ? {15'h0000, status_word[{1'b1, st_bit[2:0]}]} :            // [R05]
      fc_inreg ? (sw_hit ? status_word : TYPE_WORD) :                     // [R06]
      fc_crd ? {15'h0000, out_byte[coil_idx[2:0]]} :                      // [R07] [R08]
      hr_word;

   // write data for the output byte
   wire logic coil_val = req.wdata != 16'h0000;
   wire logic [7:0] coil_mask = {7'h00, (coil_idx < 4'h2)} << coil_idx[2:0];
   wire logic [7:0] coil_byte = coil_val ? (out_byte | coil_mask) : (out_byte & ~coil_mask);
   wire logic [15:0] hr_shift = req.wdata >> ALLOC_BIT;
   wire logic wr_coil = req.valid & fc_cwr & coil_hit;
   wire logic wr_reg = req.valid & fc_hwr & hr_hit;
   wire logic [7:0] next_out_byte = wr_coil ? (coil_byte & OUT_USED_MASK) :           // [R12]
                                    wr_reg ? (hr_shift[7:0] & OUT_USED_MASK) : out_byte;

   // answer, one cycle after the request
   wire rosm_rsp_t next_rsp = '{valid: req.valid, err: req.valid & ~(fc_ok & addr_ok),
                                data: !req.valid ? 16'h0000 :
                                      !fc_ok ? EXC_ILL_FUNC :
                                      !addr_ok ? EXC_ILL_ADDR :
                                      (fc_cwr | fc_hwr) ? req.wdata : rd_data};

   // output image and answer registers
   always_ff @(posedge clk) begin
      if (rst) begin
         out_byte <= OUT_RESET;
         rsp <= '0;
      end else begin
         out_byte <= next_out_byte; // [R07] [R08] [R09]
         rsp <= next_rsp;           // [R04]
      end
   end

   // fixed transfer period, independent of any measuring time [R02]
   assign xfer_tick = xfer_cnt == 32'(XFER_CYC - 1);
   always_ff @(posedge clk) begin
      if (rst) begin
         xfer_cnt <= 32'h0000_0000;
         xfer_strobe <= 1'b0;
         xfer_byte <= OUT_RESET;
      end else begin
         xfer_cnt <= xfer_tick ? 32'h0000_0000 : xfer_cnt + 32'h0000_0001;
         xfer_strobe <= xfer_tick;               // [R02]
         if (xfer_tick) begin
            xfer_byte <= out_byte & OUT_USED_MASK; // [R01]
         end
      end
   end

   // an attempt fails when no ack came before the next transfer
   wire logic attempt_fail = xfer_tick & ~ack_seen & ~xfer_ack;
   wire logic wd_expire = (fail_cnt == WD_FAIL_LIMIT) && (wd_cnt == 32'(WD_CYC - 1));
   always_ff @(posedge clk) begin
      if (rst) begin
         ack_seen <= 1'b1; // nothing sent before the first tick, so no failure to count
         fail_cnt <= 2'h0;
         wd_cnt <= 32'h0000_0000;
         wd_trip <= 1'b0;
      end else if (xfer_ack) begin
         ack_seen <= ~xfer_tick; // an ack in a tick cycle counts for the ending attempt
         fail_cnt <= 2'h0;
         wd_cnt <= 32'h0000_0000;
         wd_trip <= 1'b0;
      end else begin
         if (xfer_tick) begin
            ack_seen <= 1'b0;
         end
         if (attempt_fail && fail_cnt != WD_FAIL_LIMIT) begin
            fail_cnt <= fail_cnt + 2'h1; // [R11]
         end
         if (fail_cnt == WD_FAIL_LIMIT && !wd_trip) begin
            wd_cnt <= wd_cnt + 32'h0000_0001; // [R11]
         end
         if (wd_expire) begin
            wd_trip <= 1'b1; // [R11]
         end
      end
   end

   // relays follow the acknowledged byte; the watchdog forces them off
   always_ff @(posedge clk) begin
      if (rst) begin
         applied <= OUT_RESET;
         relay_out <= 2'h0;
      end else begin
         if (xfer_ack) begin
            applied <= xfer_byte;
         end
         relay_out <= (wd_trip || wd_expire) ? 2'h0 : applied[1:0]; // [R01] [R03] [R11]
      end
   end

   // helper: cycles since a write last changed the output byte
   logic [31:0] since_wr;
   always_ff @(posedge clk) begin
      if (rst || (next_out_byte != out_byte)) begin
         since_wr <= 32'h0000_0000;
      end else if (since_wr != 32'hFFFF_FFFF) begin
         since_wr <= since_wr + 32'h0000_0001;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   answer_one_cycle_a: assert property (req.valid |=> rsp.valid) // [R04]
      else $error("request not answered next cycle");
   unused_bits_zero_a: assert property ((out_byte & ~OUT_USED_MASK) == 8'h00) // [R12]
      else $error("unused output bit set");
   // an ack clears the watchdog, so two cycles on the relays show the acked byte
   relay_bit_map_a: assert property (xfer_ack |-> ##2 relay_out == $past(xfer_byte[1:0], 2)) // [R01]
      else $error("relay does not follow its output bit");
   xfer_period_a: assert property (xfer_strobe |=> !xfer_strobe) // [R02]
      else $error("transfer strobes back to back");
   // a changed output byte is on its way to the module within one period
   resp_time_a: assert property (since_wr >= 32'(XFER_CYC) |-> xfer_byte == (out_byte & OUT_USED_MASK)) // [R03]
      else $error("output change not passed on within one period");
   status_bit_read_a: assert property (req.valid && fc_sbit && st_bit != BIT_NONE |=> // [R05]
                                       !rsp.err && rsp.data[0] == $past(status_word[{1'b1, st_bit[2:0]}]))
      else $error("status bit read wrong");
   type_word_read_a: assert property (req.valid && fc_inreg && tw_hit && !sw_hit |=> // [R06]
                                      rsp.data == TYPE_WORD)
      else $error("type word read wrong");
   slot_coil_write_a: assert property (req.valid && fc_cwr && sc_bit == 4'h0 |=> // [R07]
                                       out_byte[0] == $past(coil_val))
      else $error("slot coil write lost");
   hold_reg_write_a: assert property (wr_reg && !wr_coil |=> // [R09]
                                      out_byte == ($past(hr_shift[7:0]) & OUT_USED_MASK))
      else $error("holding register write lost");
   bad_func_a: assert property (req.valid && !fc_ok |=> rsp.err && rsp.data == EXC_ILL_FUNC) // [R04]
      else $error("illegal function not refused");
   wd_off_a: assert property (wd_trip |-> relay_out == 2'h0) // [R11]
      else $error("relay on after watchdog trip");
   wd_arm_a: assert property ((fail_cnt != WD_FAIL_LIMIT) |=> !wd_trip || $past(wd_trip)) // [R11]
      else $error("watchdog tripped before three failures");

   xfer_seen_c: cover property (xfer_strobe ##1 xfer_ack);
   coil_write_c: cover property (wr_coil ##1 rsp.valid);
   wd_trip_c: cover property (!wd_trip ##1 wd_trip);
   stable_c: cover property (since_wr == 32'(XFER_CYC));

endmodule : rosm_slot_map

`default_nettype wire
